// >>> hdl/pcs_pkg.sv
// Functional notes
// - 13-bit counter, low byte software readable/writable
// - Upper bits loaded from high latch, stack top, interrupt vector or step carry
// - Every reset clears whole program counter
// - Low byte write copies latch bits 4:0
// - Call/goto take top bits from latch 4:3
// - Eight by 13-bit hidden return stack
// - Push on call and interrupt branch
// - Pop on return, literal return, interrupt return
// - Push and pop leave high latch alone
// - Stack wraps; ninth push overwrites first
// - No overflow or underflow flags
// - Indirect port accesses pointer-addressed location
// - Indirect read of port itself gives zero
// - Indirect write of port itself stores nothing
// - Indirect address is bank bit over pointer
`default_nettype none
package pcs_pkg;
	localparam int PC_W = 13;
	localparam int OPND_W = 11;
	localparam int LATCH_W = 5;
	localparam int DADDR_W = 9;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
	localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Direct file address of the indirect data port, low seven bits
	localparam logic [6:0] INDIRECT_PORT_ADDR = 7'h00;
	// Register word offsets on the bus
	localparam logic [7:0] OFS_PC_LOW = 8'h00;
	localparam logic [7:0] OFS_PC_LATCH = 8'h04;
	localparam logic [7:0] OFS_POINTER = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_PC_STATUS = 8'h10;
	localparam int CTRL_BANK_BIT = 0;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage
`default_nettype wire

// >>> hdl/pcs_return_stack.sv
`default_nettype none
module pcs_return_stack
	import pcs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Stack operations
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [PC_W-1:0] push_data_in,
	output logic [PC_W-1:0] top_out
);
	// No status flags: wrap is silent by design
	logic [PC_W-1:0] entries [STACK_DEPTH];
	logic [SP_W-1:0] sp;
	logic [SP_W-1:0] sp_below;

	assign sp_below = sp - 3'h1;
	assign top_out = entries[sp_below];

	// Pointer wraps modulo eight, oldest entry gets overwritten
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sp <= 3'h0;
		end else if (push_in) begin
			sp <= sp + 3'h1;
		end else if (pop_in) begin
			sp <= sp_below;
		end
	end

	// Storage needs no reset; contents are undefined until pushed
	always_ff @(posedge ref_clk_in) begin
		if (push_in) begin
			entries[sp] <= push_data_in;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/pcs_core.sv
`default_nettype none
module pcs_core
	import pcs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic [1:0] hresp_out,
	// Sequencing from the decoder
	input wire logic step_in,
	input wire logic goto_in,
	input wire logic call_in,
	input wire logic [OPND_W-1:0] addr_opnd_in,
	input wire logic int_branch_in,
	input wire logic return_in,
	input wire logic pc_low_wr_in,
	input wire logic [7:0] pc_low_data_in,
	// Data file access from the datapath
	input wire logic file_req_in,
	input wire logic file_we_in,
	input wire logic [DADDR_W-1:0] file_addr_in,
	input wire logic [7:0] file_wdata_in,
	input wire logic [7:0] mem_rdata_in,
	// Program and data memory side
	output logic [PC_W-1:0] prog_addr_out,
	output logic data_req_out,
	output logic data_we_out,
	output logic [DADDR_W-1:0] data_addr_out,
	output logic [7:0] data_wdata_out,
	output logic [7:0] file_rdata_out,
	output logic file_rvalid_out
);
	logic [PC_W-1:0] pc;
	logic [LATCH_W-1:0] pc_high_latch;
	logic [7:0] pointer_register;
	logic indirect_bank_bit;
	logic [PC_W-1:0] next_pc;
	logic [PC_W-1:0] stack_top;
	logic stack_push;
	logic stack_pop;
	logic [PC_W-1:0] push_value;
	logic ahb_take;
	logic ahb_wr_pend;
	logic [7:0] ahb_ofs;
	logic bus_pc_low_wr;
	logic is_indirect;
	logic [DADDR_W-1:0] eff_addr;
	logic self_target;
	logic rd_pend;
	logic rd_zero;
	logic rd_zero_d;
	logic rd_pend_d;

	// Bus side: zero wait states, write data lands one cycle after address
	assign ahb_take = hsel_in & htrans_in[1] & hready_in;
	assign bus_pc_low_wr = ahb_wr_pend && (ahb_ofs == OFS_PC_LOW);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ahb_wr_pend <= 1'b0;
			ahb_ofs <= 8'h00;
		end else if (hready_in) begin
			ahb_wr_pend <= ahb_take & hwrite_in;
			ahb_ofs <= haddr_in[7:0];
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= HRESP_OKAY;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= HRESP_OKAY;
		end
	end

	// Read data sampled at the address phase; unmapped reads give zero
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hrdata_out <= WORD_ZERO;
		end else if (ahb_take && !hwrite_in) begin
			case (haddr_in[7:0])
				OFS_PC_LOW: hrdata_out <= {24'h000000, pc[7:0]};
				OFS_PC_LATCH: hrdata_out <= {27'h0000000, pc_high_latch};
				OFS_POINTER: hrdata_out <= {24'h000000, pointer_register};
				OFS_CTRL: hrdata_out <= {31'h00000000, indirect_bank_bit};
				OFS_PC_STATUS: hrdata_out <= {19'h00000, pc};
				default: hrdata_out <= WORD_ZERO;
			endcase
		end
	end

	// Latch and pointer are software registers; stack traffic never touches them
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc_high_latch <= LATCH_RESET;
		end else if (ahb_wr_pend && ahb_ofs == OFS_PC_LATCH) begin
			pc_high_latch <= hwdata_in[LATCH_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pointer_register <= BYTE_ZERO;
		end else if (ahb_wr_pend && ahb_ofs == OFS_POINTER) begin
			pointer_register <= hwdata_in[7:0];
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			indirect_bank_bit <= 1'b0;
		end else if (ahb_wr_pend && ahb_ofs == OFS_CTRL) begin
			indirect_bank_bit <= hwdata_in[CTRL_BANK_BIT];
		end
	end

	// Priority: interrupt, return, call, goto, low-byte write, step
	assign stack_push = int_branch_in | (call_in & ~return_in);
	assign stack_pop = return_in & ~int_branch_in;
	// Interrupt saves the instruction not yet run; call saves the next one
	assign push_value = int_branch_in ? pc : pc + PC_ONE;

	always_comb begin
		next_pc = pc;
		if (int_branch_in) begin
			next_pc = INT_VECTOR;
		end else if (return_in) begin
			next_pc = stack_top;
		end else if (call_in || goto_in) begin
			next_pc = {pc_high_latch[LATCH_W-1:LATCH_W-2], addr_opnd_in};
		end else if (pc_low_wr_in) begin
			next_pc = {pc_high_latch, pc_low_data_in};
		end else if (bus_pc_low_wr) begin
			next_pc = {pc_high_latch, hwdata_in[7:0]};
		end else if (step_in) begin
			// Low-byte wrap carries into upper bits only on plain stepping
			next_pc = pc + PC_ONE;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc <= PC_RESET;
		end else begin
			pc <= next_pc;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prog_addr_out <= PC_RESET;
		end else begin
			prog_addr_out <= next_pc;
		end
	end

	pcs_return_stack u_stack (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.push_in(stack_push),
		.pop_in(stack_pop),
		.push_data_in(push_value),
		.top_out(stack_top)
	);

	// Indirect addressing through the phantom port
	assign is_indirect = file_addr_in[6:0] == INDIRECT_PORT_ADDR;
	assign eff_addr = is_indirect ? {indirect_bank_bit, pointer_register} : file_addr_in;
	assign self_target = is_indirect && (pointer_register[6:0] == INDIRECT_PORT_ADDR);
	// Only a self-pointing access reads as zero; the is_indirect term is masked off
	assign rd_pend = file_req_in & ~file_we_in;
	assign rd_zero = self_target | (is_indirect & 1'b0);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_req_out <= 1'b0;
			data_we_out <= 1'b0;
			data_addr_out <= 9'h000;
			data_wdata_out <= BYTE_ZERO;
		end else begin
			data_req_out <= file_req_in & ~self_target;
			data_we_out <= file_req_in & file_we_in & ~self_target;
			data_addr_out <= eff_addr;
			data_wdata_out <= file_wdata_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_pend_d <= 1'b0;
			rd_zero_d <= 1'b0;
		end else begin
			rd_pend_d <= rd_pend;
			rd_zero_d <= rd_zero;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			file_rvalid_out <= 1'b0;
			file_rdata_out <= BYTE_ZERO;
		end else begin
			file_rvalid_out <= rd_pend_d;
			if (rd_pend_d) begin
				file_rdata_out <= rd_zero_d ? BYTE_ZERO : mem_rdata_in;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/pcs_core_asserts.sv
`default_nettype none
module pcs_core_asserts
	import pcs_pkg::*;
(
	// Watched ports
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic hreadyout_out,
	input wire logic [1:0] hresp_out,
	input wire logic goto_in,
	input wire logic call_in,
	input wire logic [OPND_W-1:0] addr_opnd_in,
	input wire logic int_branch_in,
	input wire logic return_in,
	input wire logic pc_low_wr_in,
	input wire logic [7:0] pc_low_data_in,
	input wire logic file_req_in,
	input wire logic file_we_in,
	input wire logic [PC_W-1:0] prog_addr_out,
	input wire logic data_req_out,
	input wire logic data_we_out,
	input wire logic file_rvalid_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// Higher priority ops mask goto and low writes
	wire logic hi_pri = int_branch_in | return_in | call_in;
	property p_goto; goto_in && !hi_pri |=> prog_addr_out[10:0] == $past(addr_opnd_in); endproperty
	a_goto: assert property (p_goto) else $error("goto target wrong");
	property p_callret; (call_in && !int_branch_in && !return_in) ##1
		(return_in && !int_branch_in) |=> prog_addr_out == $past(prog_addr_out, 2) + PC_ONE;
	endproperty
	a_callret: assert property (p_callret) else $error("return address wrong");
	property p_int; int_branch_in |=> prog_addr_out == INT_VECTOR; endproperty
	a_int: assert property (p_int) else $error("vector jump wrong");
	property p_lowwr; pc_low_wr_in && !hi_pri && !goto_in |=>
		prog_addr_out[7:0] == $past(pc_low_data_in); endproperty
	a_lowwr: assert property (p_lowwr) else $error("low byte write wrong");
	property p_rvalid; file_req_in && !file_we_in |-> ##2 file_rvalid_out; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read result missing");
	property p_rvcause; file_rvalid_out |-> $past(file_req_in, 2) && !$past(file_we_in, 2);
	endproperty
	a_rvcause: assert property (p_rvcause) else $error("read result unasked");
	property p_we; data_we_out |-> data_req_out && $past(file_we_in); endproperty
	a_we: assert property (p_we) else $error("stray data write");
	property p_bus; hreadyout_out && hresp_out == HRESP_OKAY; endproperty
	a_bus: assert property (p_bus) else $error("bus response wrong");
endmodule
bind pcs_core pcs_core_asserts u_chk(.ref_clk_in, .rst_in, .hreadyout_out, .hresp_out,
	.goto_in, .call_in, .addr_opnd_in, .int_branch_in, .return_in, .pc_low_wr_in,
	.pc_low_data_in, .file_req_in, .file_we_in, .prog_addr_out, .data_req_out,
	.data_we_out, .file_rvalid_out);
`default_nettype wire

// >>> verif/pcs_mem_model.sv
`default_nettype none
module pcs_mem_model
	import pcs_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic data_req_in,
	input wire logic [DADDR_W-1:0] data_addr_in,
	output logic [7:0] mem_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip = 1'b0;
	// Idle bus toggles so stale data never passes for a match
	always @(posedge ref_clk_in) flip <= !flip;
	assign mem_rdata_out = data_req_in ? ~data_addr_in[7:0] : {8{flip}};
endmodule
`default_nettype wire

// >>> verif/program_counter_stack_indirect_tb.sv
`default_nettype none
module program_counter_stack_indirect_tb;
	import pcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] INT = 6'h20, RET = 6'h10, CALL = 6'h08;
	localparam logic [5:0] GOTO = 6'h04, LOWW = 6'h02, STEP = 6'h01;
	logic clk, rst, hsel, hwrite, step, go, cl, ib, rt, lw, fr, fw, hrdy, drq, dwe, frv;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, hresp;
	logic [10:0] opnd;
	logic [7:0] lowd, fwd, mrd, frd;
	logic [8:0] fad, dad;
	logic [12:0] pa;
	int errors = 0;
	int check_count = 0;
	pcs_core dut(.ref_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
		.step_in(step), .goto_in(go), .call_in(cl), .addr_opnd_in(opnd),
		.int_branch_in(ib), .return_in(rt), .pc_low_wr_in(lw), .pc_low_data_in(lowd),
		.file_req_in(fr), .file_we_in(fw), .file_addr_in(fad), .file_wdata_in(fwd),
		.mem_rdata_in(mrd), .prog_addr_out(pa), .data_req_out(drq), .data_we_out(dwe),
		.data_addr_out(dad), .data_wdata_out(), .file_rdata_out(frd), .file_rvalid_out(frv));
	pcs_mem_model mem(.ref_clk_in(clk), .data_req_in(drq), .data_addr_in(dad),
		.mem_rdata_out(mrd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic hw;
		int n;
		n = 0;
		@(posedge clk);
		while (hrdy !== 1'b1) begin
			n++;
			if (n > 50) begin
				errors++;
				test_done;
			end
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hw;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hw;
		r = hrdata;
	endtask
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic br(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk("reg", e, r);
	endtask
	task automatic seq(input logic [5:0] m, input logic [10:0] o, input logic [7:0] d);
		@(posedge clk);
		{ib, rt, cl, go, lw, step} <= m;
		opnd <= o;
		lowd <= d;
	endtask
	task automatic pc_is(input logic [12:0] e);
		seq(6'h0, 11'h0, 8'h0);
		#1;
		chk("pc", e, pa);
	endtask
	task automatic fa(input logic w, input logic [8:0] a, output logic q,
		output logic [8:0] da, output logic [7:0] rd);
		@(posedge clk);
		fr <= 1'b1;
		fw <= w;
		fad <= a;
		fwd <= 8'h5a;
		@(posedge clk);
		fr <= 1'b0;
		#1;
		q = drq;
		da = dad;
		@(posedge clk);
		#1;
		rd = frd;
	endtask
	task automatic t_regs;
		br(OFS_PC_STATUS, 32'h0);
		bw(OFS_PC_LATCH, 32'h15);
		bw(OFS_POINTER, 32'h45);
		bw(OFS_CTRL, 32'h1);
		br(OFS_PC_LATCH, 32'h15);
		br(OFS_POINTER, 32'h45);
		br(8'h20, 32'h0);
	endtask
	task automatic t_pc;
		seq(LOWW, 11'h0, 8'ha5);
		pc_is(13'h15a5);
		br(OFS_PC_LOW, 32'ha5);
		seq(GOTO, 11'h7ff, 8'h0);
		pc_is(13'h17ff);
		seq(STEP, 11'h0, 8'h0);
		pc_is(13'h1800);
		bw(OFS_PC_LOW, 32'h3c);
		br(OFS_PC_STATUS, 32'h153c);
		// Software bumps the latch itself after a low-byte rollover
		bw(OFS_PC_LATCH, 32'h16);
		bw(OFS_PC_LOW, 32'h3c);
		br(OFS_PC_STATUS, 32'h163c);
	endtask
	task automatic t_stack;
		logic [12:0] pc, stk[9];
		bw(OFS_PC_LATCH, 32'h0b);
		pc = 13'h163c;
		for (int i = 0; i < 9; i++) begin
			stk[i] = pc + 13'h1;
			pc = {2'b01, 11'(i * 9 + 3)};
			seq(CALL, pc[10:0], 8'h0);
			pc_is(pc);
		end
		for (int i = 8; i > 0; i--) begin
			seq(RET, 11'h0, 8'h0);
			pc_is(stk[i]);
		end
		// Ninth pop lands on the slot the ninth push overwrote
		seq(RET, 11'h0, 8'h0);
		pc_is(stk[8]);
		br(OFS_PC_LATCH, 32'h0b);
		seq(INT, 11'h0, 8'h0);
		pc_is(INT_VECTOR);
		seq(RET, 11'h0, 8'h0);
		pc_is(stk[8]);
		seq(CALL, 11'h10, 8'h0);
		seq(RET, 11'h0, 8'h0);
		pc_is(stk[8] + 13'h1);
	endtask
	task automatic t_ind;
		logic q;
		logic [8:0] da;
		logic [7:0] rd;
		fa(1'b0, 9'h100, q, da, rd);
		chk("addr", 9'h145, da);
		chk("rdata", 8'hba, rd);
		fa(1'b1, 9'h000, q, da, rd);
		chk("wr req", 1'b1, q);
		bw(OFS_POINTER, 32'h80);
		fa(1'b0, 9'h080, q, da, rd);
		chk("self rd", 8'h0, rd);
		fa(1'b1, 9'h000, q, da, rd);
		chk("self wr", 1'b0, q);
	endtask
	initial begin
		#200000;
		errors++;
		test_done;
	end
	initial begin
		rst = 1'b1;
		{hsel, hwrite, fr, fw, ib, rt, cl, go, lw, step} = 10'h0;
		{haddr, hwdata, htrans, opnd, lowd, fad, fwd} = 102'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_pc;
		t_stack;
		t_ind;
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		chk("pc rst", 13'h0, pa);
		@(posedge clk);
		rst <= 1'b0;
		test_done;
	end
endmodule
`default_nettype wire
